/* hw/acs_map.vh */
// Register offsets, field positions and timing counts for the add-on control/status block
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_CTRL_STAT 8'h6C
`define ACS_OFF_WR_COUNT 8'h58
`define ACS_WR_COUNT_RESET 32'h00000000
`define ACS_BIT_NV_GO 31
`define ACS_BIT_NV_OP_HI 30
`define ACS_BIT_NV_OP_LO 29
`define ACS_BIT_COUNT_EN 28
`define ACS_BIT_MBOX_RST 27
`define ACS_BIT_OUT_RST 26
`define ACS_BIT_IN_RST 25
`define ACS_NV_DATA_HI 23
`define ACS_NV_DATA_LO 16
`define ACS_TEST_HI 15
`define ACS_TEST_LO 12
`define ACS_BIT_WR_ZERO 7
`define ACS_BIT_RD_ZERO 6
`define ACS_NV_OP_LOW_ADDR 2'h0
`define ACS_NV_OP_HIGH_ADDR 2'h1
`define ACS_NV_OP_WRITE 2'h2
`define ACS_NV_OP_READ 2'h3
`define ACS_NV_ACCESS_NS 240
`define ACS_CLOCK_NS 10
`endif

/* hw/acs_nv_port.v */
// Sequencer for the external non-volatile memory byte port
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_nv_port #(
	parameter ACCESS_CYCLES = (`ACS_NV_ACCESS_NS + `ACS_CLOCK_NS - 1) / `ACS_CLOCK_NS
) (
	input wire clock,
	input wire rstn,
	input wire ce,
	input wire start,
	input wire [1:0] op,
	input wire [7:0] wdata,
	input wire [7:0] nv_rdata_sync,
	output reg busy_reg,
	output reg [7:0] byte_reg,
	output reg [15:0] nv_addr_reg,
	output reg [7:0] nv_wdata_reg,
	output reg nv_we_reg,
	output reg nv_oe_reg
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WR = 3'b010;
	localparam ST_RD = 3'b100;
	reg [2:0] state_reg;
	reg [15:0] cnt_reg;

	// Address loads finish at once; reads and writes hold the bus for one access time
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			busy_reg <= 1'b0;
			byte_reg <= 8'h00;
			nv_addr_reg <= 16'h0000;
			nv_wdata_reg <= 8'h00;
			nv_we_reg <= 1'b0;
			nv_oe_reg <= 1'b0;
		end else if (ce) begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						byte_reg <= wdata;
						case (op)
							`ACS_NV_OP_LOW_ADDR: nv_addr_reg[7:0] <= wdata;
							`ACS_NV_OP_HIGH_ADDR: nv_addr_reg[15:8] <= wdata;
							`ACS_NV_OP_WRITE: begin
								nv_wdata_reg <= wdata;
								nv_we_reg <= 1'b1;
								busy_reg <= 1'b1;
								cnt_reg <= ACCESS_CYCLES[15:0];
								state_reg <= ST_WR;
							end
							default: begin
								nv_oe_reg <= 1'b1;
								busy_reg <= 1'b1;
								cnt_reg <= ACCESS_CYCLES[15:0];
								state_reg <= ST_RD;
							end
						endcase
					end
				end
				ST_WR, ST_RD: begin
					if (cnt_reg <= 16'h0001) begin
						if (state_reg == ST_RD) begin
							byte_reg <= nv_rdata_sync;
						end
						nv_we_reg <= 1'b0;
						nv_oe_reg <= 1'b0;
						busy_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // acs_nv_port

/* hw/acs_ctrl_status.v */
// Add-on general control/status register and master write byte count register
//
// Contract
// - Count enable bit 28 makes transfers obey byte counts; clear ignores them.
// - Writing one to bit 27 pulses mailbox flags empty; reads zero.
// - Writing one to bit 26 resets outbound FIFO flags; reads zero.
// - Writing one to bit 25 resets inbound FIFO flags; reads zero.
// - Bits 23:16 carry nv low address, high address or data; reads return byte.
// - Bits 15:12 mirror self-test result bits 3 to 0.
// - Bit 7 reads one when write byte count is zero.
// - Bit 6 reads one when read byte count is zero.
// - Bits 5,4,3 report inbound FIFO empty, four-plus spaces, full.
// - Bits 2,1,0 report outbound FIFO empty, four-plus words, full.
// - Write byte count at 58h, 32 bits, resets zero, needs add-on mastering.
// - Count decrements per bus master write; transfer stops at zero.
// - Reaching zero may raise an interrupt toward PCI or add-on side.
// - A count not a word multiple ends with a partial final cycle.
// - Bits 31:29 code 100/101/110/111 load low, high, write, read; bit 31 busy.
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_ctrl_status (
	input wire clock,
	input wire rstn,
	input wire ce,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_addr,
	input wire [3:0] bus_be,
	input wire [31:0] bus_wdata,
	output reg [31:0] bus_rdata_reg,
	input wire addon_master_en,
	input wire irq_to_addon_sel,
	input wire [3:0] self_test_result,
	input wire rd_count_zero,
	input wire in_fifo_empty,
	input wire in_fifo_four_space,
	input wire in_fifo_full,
	input wire out_fifo_empty,
	input wire out_fifo_four_words,
	input wire out_fifo_full,
	input wire xfer_phase,
	input wire [2:0] xfer_bytes,
	output reg xfer_allow_reg,
	output reg [3:0] xfer_be_reg,
	output reg count_en_reg,
	output reg mbox_flag_rst_reg,
	output reg out_fifo_rst_reg,
	output reg in_fifo_rst_reg,
	output reg wr_zero_pci_irq_reg,
	output reg wr_zero_addon_irq_reg,
	input wire [7:0] nv_rdata,
	output wire [15:0] nv_addr,
	output wire [7:0] nv_wdata,
	output wire nv_we,
	output wire nv_oe
);
	reg [31:0] wr_count_reg;
	reg [31:0] wr_count_next;
	reg [7:0] nv_meta_reg;
	reg [7:0] nv_sync_reg;
	wire nv_busy;
	wire [7:0] nv_byte;
	wire ctrl_sel;
	wire count_sel;
	wire nv_start;
	// Decoded strobes shared by the count, the control bits and the nv port
	wire ctrl_wr;
	wire count_wr;
	wire xfer_take;
	wire zero_hit;
	wire [31:0] status_word;

	// Apply byte enables to a 32-bit register value
	function [31:0] acs_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] be;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				acs_merge[i*8 +: 8] = be[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
			end
		end
	endfunction

	// Lane mask for a final phase carrying fewer than four bytes
	function [3:0] acs_lanes;
		input [31:0] count;
		begin
			case (count)
				32'h00000001: acs_lanes = 4'h1;
				32'h00000002: acs_lanes = 4'h3;
				32'h00000003: acs_lanes = 4'h7;
				default: acs_lanes = 4'hF;
			endcase
		end
	endfunction

	// True when a byte count has run out; the flag, the gate and the pulse all ask this
	function acs_is_zero;
		input [31:0] count;
		begin
			acs_is_zero = (count == 32'h00000000);
		end
	endfunction

	// Address decode; the count register vanishes from the map while add-on mastering is off
	assign ctrl_sel = (bus_addr == `ACS_OFF_CTRL_STAT);
	assign count_sel = (bus_addr == `ACS_OFF_WR_COUNT) && addon_master_en;
	// Control bits all live in the top byte lane, so a write without that lane leaves them alone
	assign ctrl_wr = bus_wr && ctrl_sel && bus_be[3];
	assign count_wr = bus_wr && count_sel;
	// A new nv command is refused while busy; the far side must poll first
	assign nv_start = ctrl_wr && bus_wdata[`ACS_BIT_NV_GO] && !nv_busy;
	// A data phase counts only with counting on and bytes left; a bus write to the count wins
	assign xfer_take = xfer_phase && count_en_reg && !acs_is_zero(wr_count_reg) && !count_wr;
	// Only a transfer that empties the count pulses; rewriting the count to zero does not
	assign zero_hit = xfer_take && acs_is_zero(wr_count_next);

	// Status word as read back; read-only inputs are mirrored live, never stored
	assign status_word = {nv_busy, 2'b00, count_en_reg, 4'h0, nv_byte,
		self_test_result, 4'h0,
		acs_is_zero(wr_count_reg), rd_count_zero,
		in_fifo_empty, in_fifo_four_space, in_fifo_full,
		out_fifo_empty, out_fifo_four_words, out_fifo_full};

	// Read data from the pin is brought into the clock domain
	// The byte is taken only after it has stood for most of an access, so its lanes settle together
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			nv_meta_reg <= 8'h00;
			nv_sync_reg <= 8'h00;
		end else if (ce) begin
			nv_meta_reg <= nv_rdata;
			nv_sync_reg <= nv_meta_reg;
		end
	end

	// The nv sequencer drives the memory pins; this block decodes commands and synchronizes read data for it
	acs_nv_port u_nv (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.start(nv_start),
		.op(bus_wdata[`ACS_BIT_NV_OP_HI:`ACS_BIT_NV_OP_LO]),
		.wdata(bus_wdata[`ACS_NV_DATA_HI:`ACS_NV_DATA_LO]),
		.nv_rdata_sync(nv_sync_reg),
		.busy_reg(nv_busy),
		.byte_reg(nv_byte),
		.nv_addr_reg(nv_addr),
		.nv_wdata_reg(nv_wdata),
		.nv_we_reg(nv_we),
		.nv_oe_reg(nv_oe)
	);

	// Next byte count: a bus write wins over a data phase in the same cycle
	always @* begin
		wr_count_next = wr_count_reg;
		if (count_wr) begin
			wr_count_next = acs_merge(wr_count_reg, bus_wdata, bus_be);
		end else if (xfer_take) begin
			// Saturate so a phase larger than what is left never wraps the count
			if ({29'h0, xfer_bytes} >= wr_count_reg) begin
				wr_count_next = 32'h00000000;
			end else begin
				wr_count_next = wr_count_reg - {29'h0, xfer_bytes};
			end
		end
	end

	// Register state, strobes and the transfer gate
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_count_reg <= `ACS_WR_COUNT_RESET;
			count_en_reg <= 1'b0;
			mbox_flag_rst_reg <= 1'b0;
			out_fifo_rst_reg <= 1'b0;
			in_fifo_rst_reg <= 1'b0;
			// The gate opens at reset since counting starts disabled
			xfer_allow_reg <= 1'b1;
			xfer_be_reg <= 4'hF;
			wr_zero_pci_irq_reg <= 1'b0;
			wr_zero_addon_irq_reg <= 1'b0;
		end else if (ce) begin
			wr_count_reg <= wr_count_next;
			// Bit 28 is stored; the strobes below are not
			if (ctrl_wr) begin
				count_en_reg <= bus_wdata[`ACS_BIT_COUNT_EN];
			end
			// One-cycle strobes; the bits themselves are never stored
			mbox_flag_rst_reg <= ctrl_wr && bus_wdata[`ACS_BIT_MBOX_RST];
			out_fifo_rst_reg <= ctrl_wr && bus_wdata[`ACS_BIT_OUT_RST];
			in_fifo_rst_reg <= ctrl_wr && bus_wdata[`ACS_BIT_IN_RST];
			// With counting off the engine runs unbounded on full lanes
			xfer_allow_reg <= !count_en_reg || !acs_is_zero(wr_count_next);
			// The lane mask follows the enable one cycle late; set the enable before starting
			xfer_be_reg <= count_en_reg ? acs_lanes(wr_count_next) : 4'hF;
			// Pulse on the cycle the count lands on zero from a transfer
			wr_zero_pci_irq_reg <= zero_hit && !irq_to_addon_sel;
			wr_zero_addon_irq_reg <= zero_hit && irq_to_addon_sel;
		end
	end

	// Read mux; reserved and write-only bits read zero, unmapped reads zero
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bus_rdata_reg <= 32'h00000000;
		end else if (ce) begin
			// Unmapped reads return zero so a stray poll never sees a busy bit
			if (bus_rd && ctrl_sel) begin
				bus_rdata_reg <= status_word;
			end else if (bus_rd && count_sel) begin
				bus_rdata_reg <= wr_count_reg;
			end else begin
				bus_rdata_reg <= 32'h00000000;
			end
		end
	end
endmodule // acs_ctrl_status

/* tb/acs_nv_model.sv */
// Behavioural model of the external non-volatile byte memory
`timescale 1ns/10ps
module acs_nv_model (
	input wire clock,
	input wire [15:0] nv_addr,
	input wire [7:0] nv_wdata,
	input wire nv_we,
	input wire nv_oe,
	output reg [7:0] nv_rdata
);
	reg [7:0] mem [0:65535];
	initial nv_rdata = 8'h00;
	// Undriven data pins toggle so a stale byte can never pass for a real read
	always @(posedge clock) begin
		if (nv_we) begin
			mem[nv_addr] <= nv_wdata;
		end
		nv_rdata <= nv_oe ? mem[nv_addr] : ~nv_rdata;
	end
endmodule // acs_nv_model

/* tb/acs_monitor.sv */
// Checker for the add-on control/status register ports
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_monitor (
	input wire clock,
	input wire rstn,
	input wire ce,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_addr,
	input wire [3:0] bus_be,
	input wire [31:0] bus_wdata,
	input wire [31:0] bus_rdata_reg,
	input wire addon_master_en,
	input wire [3:0] self_test_result,
	input wire count_en_reg,
	input wire mbox_flag_rst_reg,
	input wire out_fifo_rst_reg,
	input wire in_fifo_rst_reg,
	input wire wr_zero_pci_irq_reg,
	input wire xfer_allow_reg
);
	// Accepted accesses to the control/status register; a write needs the top byte lane
	wire cw = ce && bus_wr && bus_addr == `ACS_OFF_CTRL_STAT && bus_be[3];
	wire cr = ce && bus_rd && bus_addr == `ACS_OFF_CTRL_STAT;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	mbox_pulse_a: assert property (cw && bus_wdata[27] |=> mbox_flag_rst_reg) else $error("no mailbox pulse");
	out_pulse_a: assert property (cw && bus_wdata[26] |=> out_fifo_rst_reg) else $error("no outbound pulse");
	in_pulse_a: assert property (cw && bus_wdata[25] |=> in_fifo_rst_reg) else $error("no inbound pulse");
	count_enable_a: assert property (cw |=> count_en_reg == $past(bus_wdata[28])) else $error("enable bit");
	self_test_a: assert property (cr |=> bus_rdata_reg[15:12] == $past(self_test_result)) else $error("self test");
	reserved_zero_a: assert property (cr |=> bus_rdata_reg[27:24] == 4'h0 && bus_rdata_reg[11:8] == 4'h0)
		else $error("write-only bits read nonzero");
	count_refused_a: assert property (ce && bus_rd && bus_addr == `ACS_OFF_WR_COUNT && !addon_master_en
		|=> bus_rdata_reg == 32'h0) else $error("count readable while mastering off");
	zero_stop_a: assert property (wr_zero_pci_irq_reg |-> !xfer_allow_reg) else $error("transfer runs at zero");
	cover property (cw && bus_wdata[27]);
	cover property (wr_zero_pci_irq_reg);
	cover property (cr);
endmodule // acs_monitor
bind acs_ctrl_status acs_monitor i_mon (.clock(clock), .rstn(rstn), .ce(ce), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata_reg(bus_rdata_reg),
	.addon_master_en(addon_master_en), .self_test_result(self_test_result), .count_en_reg(count_en_reg),
	.mbox_flag_rst_reg(mbox_flag_rst_reg), .out_fifo_rst_reg(out_fifo_rst_reg), .in_fifo_rst_reg(in_fifo_rst_reg),
	.wr_zero_pci_irq_reg(wr_zero_pci_irq_reg), .xfer_allow_reg(xfer_allow_reg));

/* tb/tb_addon_control_status_write_count.sv */
// Testbench for the add-on control/status and write byte count registers
`timescale 1ns/10ps
`include "acs_map.vh"
module tb_addon_control_status_write_count;
	reg clock = 0, rstn = 0, ce = 1, bus_wr = 0, bus_rd = 0, addon_master_en = 1, irq_to_addon_sel = 0;
	reg xfer_phase = 0, rd_count_zero = 1;
	reg [7:0] bus_addr = 8'h00;
	reg [3:0] bus_be = 4'hF, self_test_result = 4'hA;
	reg [31:0] bus_wdata = 32'h0, d;
	reg [2:0] xfer_bytes = 3'h4;
	reg [5:0] fifo = 6'h29;
	wire [31:0] rdata;
	wire [15:0] nv_addr;
	wire [7:0] nv_wdata, nv_rdata;
	wire [3:0] be;
	wire allow, zp, za, nv_we, nv_oe;
	integer errors = 0, comparisons = 0, cycles = 0, i, s;
	always #5 clock = ~clock;
	acs_ctrl_status i_dut (.clock(clock), .rstn(rstn), .ce(ce), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
		.bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata_reg(rdata), .addon_master_en(addon_master_en),
		.irq_to_addon_sel(irq_to_addon_sel), .self_test_result(self_test_result), .rd_count_zero(rd_count_zero),
		.in_fifo_empty(fifo[5]), .in_fifo_four_space(fifo[4]), .in_fifo_full(fifo[3]), .out_fifo_empty(fifo[2]),
		.out_fifo_four_words(fifo[1]), .out_fifo_full(fifo[0]), .xfer_phase(xfer_phase), .xfer_bytes(xfer_bytes),
		.xfer_allow_reg(allow), .xfer_be_reg(be), .count_en_reg(), .mbox_flag_rst_reg(), .out_fifo_rst_reg(),
		.in_fifo_rst_reg(), .wr_zero_pci_irq_reg(zp), .wr_zero_addon_irq_reg(za), .nv_rdata(nv_rdata),
		.nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_we(nv_we), .nv_oe(nv_oe));
	acs_nv_model i_nv (.clock(clock), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_we(nv_we), .nv_oe(nv_oe),
		.nv_rdata(nv_rdata));
	// Register bus cycles; inputs move on the falling edge, read data is taken on the next falling edge
	task wr(input [7:0] a, input [31:0] v);
		begin
			@(negedge clock) bus_addr = a;
			bus_wdata = v;
			bus_wr = 1;
			@(negedge clock) bus_wr = 0;
		end
	endtask
	task rd(input [7:0] a, output [31:0] v);
		begin
			@(negedge clock) bus_addr = a;
			bus_rd = 1;
			@(negedge clock) bus_rd = 0;
			v = rdata;
		end
	endtask
	task ph(input [2:0] b);
		begin
			@(negedge clock) xfer_bytes = b;
			xfer_phase = 1;
			@(negedge clock) xfer_phase = 0;
		end
	endtask
	task chk(input [63:0] n, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("unexpected %0s: expected %h seen %h", n, e, g);
			end
		end
	endtask
	// Memory command with counting kept on, then poll until ready
	task nv(input [2:0] op, input [7:0] b);
		begin
			wr(`ACS_OFF_CTRL_STAT, {op, 5'h10, b, 16'h0});
			d = 32'h80000000;
			for (i = 0; i < 40 && d[31]; i = i + 1) rd(`ACS_OFF_CTRL_STAT, d);
			chk("busy", 32'h0, {31'h0, d[31]});
		end
	endtask
	task final_report;
		begin
			$display("errors %0d comparisons %0d", errors, comparisons);
			if (errors == 0 && comparisons > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// Hang guard well beyond the roughly 120 cycles the sequence needs
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			final_report;
		end
	end
	initial begin
		repeat (16) @(negedge clock);
		rstn = 1;
		rd(`ACS_OFF_WR_COUNT, d);
		chk("count", 32'h0, d);
		wr(`ACS_OFF_CTRL_STAT, 32'h0);
		wr(`ACS_OFF_WR_COUNT, 32'h4);
		ph(3'h4);
		rd(`ACS_OFF_WR_COUNT, d);
		chk("count", 32'h4, d);
		wr(`ACS_OFF_CTRL_STAT, 32'h1E000000);
		for (s = 0; s < 2; s = s + 1) begin
			irq_to_addon_sel = s[0];
			wr(`ACS_OFF_WR_COUNT, 32'h5);
			ph(3'h4);
			chk("lanes", 32'h1, {28'h0, be});
			ph(3'h1);
			chk("allow", 32'h0, {31'h0, allow});
			chk("irq", s ? 32'h2 : 32'h1, {30'h0, za, zp});
			rd(`ACS_OFF_WR_COUNT, d);
			chk("count", 32'h0, d);
		end
		wr(`ACS_OFF_WR_COUNT, 32'h3);
		addon_master_en = 0;
		wr(`ACS_OFF_WR_COUNT, 32'h7);
		rd(`ACS_OFF_WR_COUNT, d);
		chk("count", 32'h0, d);
		addon_master_en = 1;
		rd(`ACS_OFF_WR_COUNT, d);
		chk("count", 32'h3, d);
		wr(`ACS_OFF_WR_COUNT, 32'h0);
		nv(3'h4, 8'h34);
		nv(3'h5, 8'h12);
		nv(3'h6, 8'h5A);
		nv(3'h7, 8'h00);
		rd(`ACS_OFF_CTRL_STAT, d);
		chk("status", 32'h105AA0E9, d);
		final_report;
	end
endmodule // tb_addon_control_status_write_count
